// file: pkg/csf_pkg.sv
/*
  Package for the CPU status flag block: register offsets, bit positions,
  reset values and the packed struct that carries datapath events.
  Assumes a 32-bit AHB-Lite register bus with one word per register.
*/
`default_nettype none
package csf_pkg;
  // Byte offsets of the software-visible registers
  localparam logic [7:0] CSF_OFF_STATUS = 8'h00;
  localparam logic [7:0] CSF_OFF_CTRL = 8'h04;
  localparam logic [7:0] CSF_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] CSF_OFF_IRQ_MASK = 8'h0C;
  // Bit positions of the status word
  localparam int CSF_BIT_OVF_A = 15;
  localparam int CSF_BIT_OVF_B = 14;
  localparam int CSF_BIT_SAT_A = 13;
  localparam int CSF_BIT_SAT_B = 12;
  localparam int CSF_BIT_OVF_ANY = 11;
  localparam int CSF_BIT_SAT_ANY = 10;
  localparam int CSF_BIT_LOOP = 9;
  localparam int CSF_BIT_HCARRY = 8;
  localparam int CSF_BIT_PRIO_LO = 5;
  localparam int CSF_BIT_RA = 4;
  localparam int CSF_BIT_N = 3;
  localparam int CSF_BIT_OV = 2;
  localparam int CSF_BIT_Z = 1;
  localparam int CSF_BIT_C = 0;
  // Nesting-disable bit position in the control register
  localparam int CSF_BIT_NEST_DIS = 0;
  // Interrupt status bit positions
  localparam int CSF_IRQ_SAT_A = 0;
  localparam int CSF_IRQ_SAT_B = 1;
  localparam int CSF_IRQ_OVF_A = 2;
  localparam int CSF_IRQ_OVF_B = 3;
  localparam int CSF_IRQ_W = 4;
  // Reset values
  localparam logic [15:0] CSF_STATUS_RST = 16'h0000;
  localparam logic [2:0] CSF_PRIO_RST = 3'h0;
  localparam logic [CSF_IRQ_W-1:0] CSF_IRQ_RST = 4'h0;
  // Half-carry tap bits: byte ops carry out of bit 3, words out of bit 7
  localparam int CSF_HC_BYTE_BIT = 4;
  localparam int CSF_HC_WORD_BIT = 8;

  // Datapath events presented to the flag logic in one cycle
  typedef struct packed {
    logic valid;        // Result qualifies flag updates
    logic byte_op;      // Byte-sized operation
    logic [15:0] op_a;  // First operand
    logic [15:0] op_b;  // Second operand
    logic carry_in;     // Carry into the add
    logic ovf_a;        // Accumulator A overflowed this op
    logic ovf_b;        // Accumulator B overflowed this op
    logic upd_a;        // Op targets accumulator A
    logic upd_b;        // Op targets accumulator B
    logic sat_a;        // Accumulator A saturated
    logic sat_b;        // Accumulator B saturated
    logic n;            // Result negative
    logic ov;           // Arithmetic overflow
    logic z;            // Result zero
    logic c;            // Carry out
  } csf_alu_evt_type;
endpackage
`default_nettype wire

// file: hdl/csf_cpu_status_flags.sv
/*
  CPU status flag block: keeps the 16-bit cpu_status_word, updated by
  datapath events and reached by software over an AHB-Lite slave.
  Assumes a single 125 MHz clock with synchronous datapath inputs.
*/
//
// Summary of operation
// - Saturation A sets sticky flag until cleared
// - Saturation B sets sticky flag until cleared
// - Overflow B flag follows last B operation
// - Clearing combined saturation clears both stickies
// - Priority field read-only while nesting disabled
// - Half-carry from bit four or eight
`timescale 1ns/10ps
`default_nettype none
module csf_cpu_status_flags (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire csf_pkg::csf_alu_evt_type alu_evt,
  input wire logic loop_active,
  input wire logic ipl_bit3,
  output logic [15:0] cpu_status_word,
  output logic irq
);

  // Address phase capture
  logic wr_pend_q;
  logic [7:0] addr_q;
  // Flag storage
  logic acc_a_overflow_flag_q;
  logic acc_b_overflow_flag_q;
  logic acc_a_saturation_sticky_q;
  logic acc_b_saturation_sticky_q;
  logic loop_active_flag_q;
  logic half_carry_flag_q;
  logic [2:0] interrupt_priority_level_q;
  logic ra_q;
  logic [3:0] arith_q;
  logic interrupt_nesting_disable_q;
  logic [csf_pkg::CSF_IRQ_W-1:0] irq_stat_q;
  logic [csf_pkg::CSF_IRQ_W-1:0] irq_mask_q;
  logic combined_overflow_flag;
  logic combined_saturation_sticky;
  logic half_carry;
  logic [8:0] low_sum; // Low byte sum, bit 8 is the word tap
  logic [4:0] nib_sum; // Low nibble sum, bit 4 is the byte tap
  logic [2:0] prio_wdata; // Priority field of the write data
  logic [csf_pkg::CSF_IRQ_W-1:0] irq_evt;

  // Every assertion below runs on the bus clock and sleeps in reset
  default clocking cb_flags @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Write strobe decode, used by several processes
  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] off);
    wr_hit = pend && (a == off);
  endfunction

  // Always ready, always OKAY: every access finishes in one data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Capture of write address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  logic wr_st;
  logic wr_ctl;
  logic wr_ist;
  logic wr_msk;
  assign wr_st = wr_hit(wr_pend_q, addr_q, csf_pkg::CSF_OFF_STATUS);
  assign wr_ctl = wr_hit(wr_pend_q, addr_q, csf_pkg::CSF_OFF_CTRL);
  assign wr_ist = wr_hit(wr_pend_q, addr_q, csf_pkg::CSF_OFF_IRQ_STAT);
  assign wr_msk = wr_hit(wr_pend_q, addr_q, csf_pkg::CSF_OFF_IRQ_MASK);

  // Half-carry: add low bits and take carry out of the tap
  assign low_sum = {1'b0, alu_evt.op_a[7:0]} + {1'b0, alu_evt.op_b[7:0]}
                 + {8'h00, alu_evt.carry_in};
  // Separate nibble adder so the byte tap never sees bits above 3
  assign nib_sum = {1'b0, alu_evt.op_a[3:0]} + {1'b0, alu_evt.op_b[3:0]}
                 + {4'h0, alu_evt.carry_in};
  always_comb begin
    half_carry = 1'b0;
    if (alu_evt.byte_op) begin
      half_carry = nib_sum[csf_pkg::CSF_HC_BYTE_BIT];
    end else begin
      half_carry = low_sum[csf_pkg::CSF_HC_WORD_BIT];
    end
  end

  // Accumulator overflow flags track the latest targeting op
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_a_overflow_flag_q <= 1'b0;
      acc_b_overflow_flag_q <= 1'b0;
    end else if (alu_evt.valid) begin
      if (alu_evt.upd_a) begin
        acc_a_overflow_flag_q <= alu_evt.ovf_a;
      end
      if (alu_evt.upd_b) begin
        acc_b_overflow_flag_q <= alu_evt.ovf_b;
      end
    end
  end

  // Sticky saturation: set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_a_saturation_sticky_q <= 1'b0;
      acc_b_saturation_sticky_q <= 1'b0;
    end else begin
      if (alu_evt.valid && alu_evt.sat_a) begin
        acc_a_saturation_sticky_q <= 1'b1;
      end else if (wr_st && (!hwdata[csf_pkg::CSF_BIT_SAT_A]
                   || !hwdata[csf_pkg::CSF_BIT_SAT_ANY])) begin
        acc_a_saturation_sticky_q <= 1'b0;
      end
      if (alu_evt.valid && alu_evt.sat_b) begin
        acc_b_saturation_sticky_q <= 1'b1;
      end else if (wr_st && (!hwdata[csf_pkg::CSF_BIT_SAT_B]
                   || !hwdata[csf_pkg::CSF_BIT_SAT_ANY])) begin
        acc_b_saturation_sticky_q <= 1'b0;
      end
    end
  end

  // Combined flags are derived, never stored
  assign combined_overflow_flag = acc_a_overflow_flag_q
                                | acc_b_overflow_flag_q;
  assign combined_saturation_sticky = acc_a_saturation_sticky_q
                                    | acc_b_saturation_sticky_q;

  // Arithmetic flags: hardware update takes priority over a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_carry_flag_q <= 1'b0;
      arith_q <= 4'h0;
      ra_q <= 1'b0;
      loop_active_flag_q <= 1'b0;
    end else begin
      loop_active_flag_q <= loop_active;
      if (alu_evt.valid) begin
        half_carry_flag_q <= half_carry;
        arith_q <= {alu_evt.n, alu_evt.ov, alu_evt.z, alu_evt.c};
      end else if (wr_st) begin
        half_carry_flag_q <= hwdata[csf_pkg::CSF_BIT_HCARRY];
        arith_q <= hwdata[csf_pkg::CSF_BIT_N:csf_pkg::CSF_BIT_C];
      end
    end
  end

  // Priority bits picked out of the write data
  assign prio_wdata = hwdata[csf_pkg::CSF_BIT_PRIO_LO +: 3];

  // Priority field: frozen while nesting is disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_priority_level_q <= csf_pkg::CSF_PRIO_RST;
    end else if (wr_st && !interrupt_nesting_disable_q) begin
      interrupt_priority_level_q <= prio_wdata;
    end
  end

  // Nesting-disable control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_nesting_disable_q <= 1'b0;
    end else if (wr_ctl) begin
      interrupt_nesting_disable_q <= hwdata[csf_pkg::CSF_BIT_NEST_DIS];
    end
  end

  // Interrupt events: saturation and overflow per accumulator
  assign irq_evt = {alu_evt.valid & alu_evt.upd_b & alu_evt.ovf_b,
                    alu_evt.valid & alu_evt.upd_a & alu_evt.ovf_a,
                    alu_evt.valid & alu_evt.sat_b,
                    alu_evt.valid & alu_evt.sat_a};

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= csf_pkg::CSF_IRQ_RST;
    end else begin
      irq_stat_q <= irq_evt | (irq_stat_q
                  & ~(wr_ist ? hwdata[csf_pkg::CSF_IRQ_W-1:0] : 4'h0));
    end
  end

  // Interrupt mask register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_q <= csf_pkg::CSF_IRQ_RST;
    end else if (wr_msk) begin
      irq_mask_q <= hwdata[csf_pkg::CSF_IRQ_W-1:0];
    end
  end

  // Level interrupt output, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Assembled status word; ra reads ra_q, which stays at its reset zero since ipl_bit3 is unused
  always_comb begin
    cpu_status_word = csf_pkg::CSF_STATUS_RST;
    cpu_status_word[csf_pkg::CSF_BIT_OVF_A] = acc_a_overflow_flag_q;
    cpu_status_word[csf_pkg::CSF_BIT_OVF_B] = acc_b_overflow_flag_q;
    cpu_status_word[csf_pkg::CSF_BIT_SAT_A] = acc_a_saturation_sticky_q;
    cpu_status_word[csf_pkg::CSF_BIT_SAT_B] = acc_b_saturation_sticky_q;
    cpu_status_word[csf_pkg::CSF_BIT_OVF_ANY] = combined_overflow_flag;
    cpu_status_word[csf_pkg::CSF_BIT_SAT_ANY] = combined_saturation_sticky;
    cpu_status_word[csf_pkg::CSF_BIT_LOOP] = loop_active_flag_q;
    cpu_status_word[csf_pkg::CSF_BIT_HCARRY] = half_carry_flag_q;
    cpu_status_word[csf_pkg::CSF_BIT_PRIO_LO +: 3] =
      interrupt_priority_level_q;
    cpu_status_word[csf_pkg::CSF_BIT_RA] = ra_q;
    cpu_status_word[csf_pkg::CSF_BIT_N:csf_pkg::CSF_BIT_C] = arith_q;
  end

  // Read data registered in the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        csf_pkg::CSF_OFF_STATUS: hrdata <= {16'h0000, cpu_status_word};
        csf_pkg::CSF_OFF_CTRL:
          hrdata <= {31'h0, interrupt_nesting_disable_q};
        csf_pkg::CSF_OFF_IRQ_STAT: hrdata <= {28'h0, irq_stat_q};
        csf_pkg::CSF_OFF_IRQ_MASK: hrdata <= {28'h0, irq_mask_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions, clocked and disabled by the defaults at the top
  a_sat_a_sticky: assert property (
    (alu_evt.valid && alu_evt.sat_a) |=> acc_a_saturation_sticky_q)
    else $error("A saturation not latched");
  // Software clear of A, only when no saturation lands that cycle
  sequence s_sat_a_clear;
    wr_st && !hwdata[csf_pkg::CSF_BIT_SAT_A]
      && !(alu_evt.valid && alu_evt.sat_a);
  endsequence
  a_sat_a_clear: assert property (
    s_sat_a_clear |=> !acc_a_saturation_sticky_q)
    else $error("A sticky not cleared");
  a_sat_b_sticky: assert property (
    (acc_b_saturation_sticky_q && !wr_st) |=> acc_b_saturation_sticky_q)
    else $error("B sticky lost without clear");
  a_ovf_b_track: assert property (
    (alu_evt.valid && alu_evt.upd_b) |=>
      (acc_b_overflow_flag_q == $past(alu_evt.ovf_b)))
    else $error("B overflow mismatch");
  a_sat_any_clear: assert property (
    (wr_st && !hwdata[csf_pkg::CSF_BIT_SAT_ANY] && !alu_evt.valid)
      |=> !cpu_status_word[csf_pkg::CSF_BIT_SAT_ANY])
    else $error("Combined clear failed");
  a_prio_frozen: assert property (
    interrupt_nesting_disable_q |=> $stable(interrupt_priority_level_q))
    else $error("Priority changed while locked");
  // Priority follows the write while nesting is enabled
  a_prio_write: assert property (
    (wr_st && !interrupt_nesting_disable_q) |=>
      (interrupt_priority_level_q == $past(prio_wdata)))
    else $error("Priority write lost");
  a_half_carry: assert property (
    alu_evt.valid |=> (half_carry_flag_q == $past(half_carry)))
    else $error("Half carry wrong");
  a_ovf_any_or: assert property (
    cpu_status_word[csf_pkg::CSF_BIT_OVF_ANY] ==
      (cpu_status_word[csf_pkg::CSF_BIT_OVF_A]
       | cpu_status_word[csf_pkg::CSF_BIT_OVF_B]))
    else $error("Combined overflow wrong");
  // A write with no datapath event must leave combined overflow alone
  a_ovf_any_ro: assert property (
    (wr_st && !alu_evt.valid) |=>
      $stable(cpu_status_word[csf_pkg::CSF_BIT_OVF_ANY]))
    else $error("Combined overflow written");
  a_irq_level: assert property (
    (|(irq_stat_q & irq_mask_q)) |=> irq)
    else $error("Interrupt not raised");
  // Level output must also drop once no unmasked cause is left
  a_irq_quiet: assert property (
    !(|(irq_stat_q & irq_mask_q)) |=> !irq)
    else $error("Interrupt stuck high");
  // Saturation of A is also latched as an interrupt cause
  a_irq_sat_a: assert property (
    (alu_evt.valid && alu_evt.sat_a) |=> irq_stat_q[csf_pkg::CSF_IRQ_SAT_A])
    else $error("Saturation interrupt lost");

endmodule // csf_cpu_status_flags
`default_nettype wire

// file: bench/tb_top.sv
/*
  Self-checking bench for the CPU status flag block.
  Assumes one 125 MHz clock and a zero-wait AHB-Lite slave.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic hclk, hresetn, hsel, hwrite, rd_dp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, loop_active, irq, hresp;
  logic [15:0] status_word; // Status word pins of the block
  csf_pkg::csf_alu_evt_type alu_evt;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int n_fail, check_count;
  localparam logic [7:0] ST = csf_pkg::CSF_OFF_STATUS;
  localparam logic [7:0] CT = csf_pkg::CSF_OFF_CTRL;
  localparam logic [7:0] IS = csf_pkg::CSF_OFF_IRQ_STAT;

  csf_cpu_status_flags csf_cpu_status_flags_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .alu_evt(alu_evt), .loop_active(loop_active),
    .ipl_bit3(1'b0), .cpu_status_word(status_word), .irq(irq)
  );

  // Free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Read data compare
  task automatic cmp_rd(input logic [31:0] e);
    check_count++;
    if (hrdata !== e || hresp !== 1'b0) begin
      n_fail++;
      $display("mismatch at %0t: read %h resp %b expected %h", $time,
               hrdata, hresp, e);
    end
  endtask

  // Status word pins, looked at after a read with nothing in flight
  task automatic cmp_word(input logic [15:0] e);
    check_count++;
    if (status_word !== e) begin
      n_fail++;
      $display("mismatch at %0t: word %h expected %h", $time, status_word, e);
    end
  endtask

  // Interrupt level compare, settled two edges after the cause
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge hclk);
    check_count++;
    if (irq !== e) begin
      n_fail++;
      $display("mismatch at %0t: irq %b expected %b", $time, irq, e);
    end
  endtask

  // Monitor pops a note at the end of each read data phase
  always @(posedge hclk) begin
    if (rd_dp) begin
      cmp_rd(exp_q.pop_front());
    end
    rd_dp <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
  end

  // One single transfer; for reads d is the expected value
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    if (!w) exp_q.push_back({16'h0000, d});
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // Flags: sat_a, sat_b, ovf_a, ovf_b, upd_a, upd_b
  function automatic csf_pkg::csf_alu_evt_type ev(input logic [5:0] f);
    csf_pkg::csf_alu_evt_type e;
    e = '0;
    e.valid = 1'b1;
    {e.sat_a, e.sat_b, e.ovf_a, e.ovf_b, e.upd_a, e.upd_b} = f;
    return e;
  endfunction

  // One-cycle datapath event, then one idle edge so that calls in a row
  // never assign the event twice in one time step
  task automatic evt(input csf_pkg::csf_alu_evt_type e);
    alu_evt <= e;
    @(posedge hclk);
    alu_evt <= '0;
    @(posedge hclk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog, far above the roughly 150 cycles the tests need
  initial begin
    repeat (3000) @(posedge hclk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report;
  end

  // Main sequence
  initial begin
    csf_pkg::csf_alu_evt_type e;
    logic [8:0] s;
    int i;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    loop_active = 1'b0;
    alu_evt = '0;
    n_fail = 0;
    check_count = 0;
    void'($urandom(32'h1abe));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, and an unmapped word reads zero
    xfer(1'b0, ST, 16'h0000);
    xfer(1'b0, CT, 16'h0000);
    xfer(1'b0, 8'h10, 16'h0000);
    // Stickies hold after the cause goes away
    evt(ev(6'b100000));
    xfer(1'b0, ST, 16'h2400);
    cmp_word(16'h2400);
    evt(ev(6'b010000));
    evt(ev(6'b000000));
    xfer(1'b0, ST, 16'h3400);
    xfer(1'b1, ST, 16'h1400);
    xfer(1'b0, ST, 16'h1400);
    evt(ev(6'b110000));
    xfer(1'b1, ST, 16'h3000);
    xfer(1'b0, ST, 16'h0000);
    cmp_word(16'h0000);
    // Interrupt masked, unmasked, then cleared
    chk_irq(1'b0);
    xfer(1'b1, csf_pkg::CSF_OFF_IRQ_MASK, 16'h0001);
    chk_irq(1'b1);
    xfer(1'b0, IS, 16'h0003);
    xfer(1'b1, IS, 16'h0001);
    chk_irq(1'b0);
    xfer(1'b0, IS, 16'h0002);
    // Overflow flags and their combined view
    evt(ev(6'b000101));
    xfer(1'b0, ST, 16'h4800);
    evt(ev(6'b001010));
    xfer(1'b0, ST, 16'hC800);
    cmp_word(16'hC800);
    evt(ev(6'b000001));
    xfer(1'b0, ST, 16'h8800);
    xfer(1'b1, ST, 16'h7400);
    xfer(1'b0, ST, 16'h8800);
    loop_active <= 1'b1;
    evt(ev(6'b000010));
    xfer(1'b0, ST, 16'h0200);
    loop_active <= 1'b0;
    // Priority field locked while nesting is disabled
    xfer(1'b1, ST, 16'h00E0);
    xfer(1'b0, ST, 16'h00E0);
    xfer(1'b1, CT, 16'h0001);
    xfer(1'b1, ST, 16'h0020);
    xfer(1'b0, ST, 16'h00E0);
    cmp_word(16'h00E0);
    xfer(1'b1, CT, 16'h0000);
    xfer(1'b1, ST, 16'h0000);
    xfer(1'b0, ST, 16'h0000);
    // Random operands for the half-carry tap
    for (i = 0; i < 16; i++) begin
      e = ev(6'b000000);
      e.byte_op = 1'($urandom);
      e.op_a = 16'($urandom);
      e.op_b = 16'($urandom);
      e.carry_in = 1'($urandom);
      {e.n, e.ov, e.z, e.c} = 4'($urandom);
      if (e.byte_op) s = 9'(e.op_a[3:0]) + 9'(e.op_b[3:0]) + 9'(e.carry_in);
      else s = 9'(e.op_a[7:0]) + 9'(e.op_b[7:0]) + 9'(e.carry_in);
      evt(e);
      xfer(1'b0, ST, {7'h00, e.byte_op ? s[4] : s[8], 4'h0,
                      e.n, e.ov, e.z, e.c});
    end
    final_report;
  end
endmodule // tb_top
`default_nettype wire
